/* File: bench/linefeed_model.sv */
// Purpose: Behavioural linefeed stage that takes the generator's samples
// Assumes: Sample enable comes from the generator on the core clock
// Notes:   Checks sample spacing and that the drive holds between pulses
`timescale 1ns/1ps
module linefeed_model #(
    parameter int unsigned SAMPLE_DIV = 20
) (
    // Clock
    input  wire logic        i_clock,
    // Drive from the generator
    input  wire logic [15:0] i_sample,
    input  wire logic        i_sample_valid,
    // Observation
    output logic      [15:0] o_gap_errors
);
    int unsigned gap = 0;
    logic [15:0] level_q = 16'h0000;
    logic [15:0] errs_q  = 16'h0000;
    assign o_gap_errors = errs_q;
    // Spacing is only judged once the first pulse has set a reference;
    // between pulses the drive must keep the level that the last pulse set
    always @(posedge i_clock) begin
        if (i_sample_valid === 1'b1) begin
            if (gap != 0 && gap != SAMPLE_DIV) errs_q <= errs_q + 16'h0001;
            gap <= 1;
            level_q <= i_sample;
        end else if (gap != 0) begin
            gap <= gap + 1;
            if (i_sample !== level_q) errs_q <= errs_q + 16'h0001;
        end
    end
endmodule : linefeed_model

/* File: bench/ringing_waveform_generator_tb.sv */
// Purpose: Self-checking bench for the ringing waveform generator
// Assumes: Shortened sample and tick dividers
// Notes:   Read data checked from a queue by a separate watcher
`timescale 1ns/1ps
module ringing_waveform_generator_tb;
    localparam int unsigned SD = 20;
    localparam int unsigned TD = 5;
    localparam logic [7:0] ADR [15] = '{8'h22, 8'h30, 8'h31, 8'h32, 8'h33, 8'h4A, 8'h60,
        8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68};
    localparam logic [7:0] MSK [15] = '{8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
    logic              i_clock;
    logic              i_arst_n = 1'b0;
    logic              i_wr     = 1'b0;
    logic              i_rd     = 1'b0;
    logic [7:0]        i_addr   = 8'h00;
    logic [7:0]        i_wdata  = 8'h00;
    logic [7:0]        o_rdata;
    logic [15:0]       o_sample;
    logic              o_sample_valid;
    logic [2:0]        o_line_state;
    logic              o_ringing;
    logic [3:0]        o_cm_bias_adjust;
    logic [5:0]        o_high_battery_setting;
    logic [15:0]       gap_errors;
    logic              rd_q = 1'b0;
    logic [7:0]        exp_q [$];
    logic [15:0]       cap [4];
    logic [15:0]       base [4];
    logic [15:0]       dlt;
    logic signed [31:0] p;
    logic [31:0]       lfsr = 32'hF05B;
    logic [5:0]        vb;
    logic [3:0]        cm;
    int                n;
    int                err_count = 0;
    int                total_checks = 0;

    ringing_waveform_generator #(.SAMPLE_DIV(SD), .TICK_DIV(TD)) i_dut (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sample(o_sample),
        .o_sample_valid(o_sample_valid), .o_line_state(o_line_state),
        .o_ringing(o_ringing), .o_cm_bias_adjust(o_cm_bias_adjust),
        .o_high_battery_setting(o_high_battery_setting));
    linefeed_model #(.SAMPLE_DIV(SD)) i_line (.i_clock(i_clock), .i_sample(o_sample),
        .i_sample_valid(o_sample_valid), .o_gap_errors(gap_errors));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // A strobe stays high between back-to-back calls of the same task; the other task or idle drops it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        @(posedge i_clock);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_addr <= a;
        i_rd <= 1'b1;
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask : rd
    task automatic idle();
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        @(posedge i_clock);
    endtask : idle
    task automatic wait_ring(input logic lvl);
        n = 0;
        while (o_ringing !== lvl && n < 200) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        repeat (2) @(posedge i_clock);
        #1;
    endtask : wait_ring
    task automatic grab();
        int k;
        k = 0;
        for (int c = 0; c < 6 * SD && k < 4; c++) begin
            @(posedge i_clock);
            #1;
            if (o_sample_valid === 1'b1) begin
                cap[k] = o_sample;
                k++;
            end
        end
        check(16'(k), 16'h0004);
    endtask : grab
    task automatic done(input string s);
        $display("test %s finished at %0t", s, $time);
    endtask : done
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Clock, read watcher, watchdog
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) rd_q <= i_rd;
    always @(negedge i_clock) if (rd_q === 1'b1) check({8'h00, o_rdata}, {8'h00, exp_q.pop_front()});
    initial begin
        repeat (5000) @(posedge i_clock);
        err_count++;
        tally_and_finish();
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (3) @(posedge i_clock);
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        for (int i = 0; i < 15; i++) rd(ADR[i], 8'h00);
        rd(8'h69, 8'h01);
        rd(8'h7F, 8'h00);
        for (int i = 0; i < 15; i++) begin
            lfsr = next_rand(lfsr);
            wr(ADR[i], lfsr[7:0]);
            rd(ADR[i], lfsr[7:0] & MSK[i]);
            if (i == 5) vb = lfsr[5:0];
            if (i == 14) cm = lfsr[3:0];
        end
        wr(8'h69, 8'hFF);
        wr(8'h7F, 8'hAA);
        rd(8'h69, 8'h01);
        rd(8'h7F, 8'h00);
        idle();
        idle();
        check(16'(o_high_battery_setting), 16'(vb));
        check(16'(o_cm_bias_adjust), 16'(cm));
        done("registers");
        // Short cadence: four ticks on, three off, sine coefficients
        wr(8'h22, 8'h00);
        wr(8'h30, 8'h04);
        wr(8'h31, 8'h00);
        wr(8'h32, 8'h03);
        wr(8'h33, 8'h00);
        wr(8'h64, 8'h77);
        wr(8'h65, 8'h01);
        wr(8'h62, 8'hFD);
        wr(8'h63, 8'h7E);
        wr(8'h66, 8'h00);
        wr(8'h67, 8'h00);
        wr(8'h22, 8'h1C);
        wr(8'h40, 8'h04);
        idle();
        @(posedge i_clock);
        #1;
        check(16'(o_line_state), 16'h0004);
        check(16'(o_ringing), 16'h0001);
        rd(8'h69, 8'h02);
        idle();
        repeat (2) begin
            wait_ring(1'b0);
            check(16'(n >= 3 * TD && n <= 4 * TD + 4), 16'h0001);
            check(16'(o_line_state), 16'h0002);
            wait_ring(1'b1);
            check(16'(n >= 2 * TD && n <= 3 * TD + 4), 16'h0001);
            check(16'(o_line_state), 16'h0004);
        end
        // Dropping both timer enables inside the off interval ends the cadence
        wait_ring(1'b0);
        wr(8'h22, 8'h10);
        idle();
        rd(8'h69, 8'h01);
        idle();
        repeat (30) @(posedge i_clock);
        #1;
        check(16'(o_ringing), 16'h0000);
        wr(8'h40, 8'h00);
        idle();
        repeat (3) @(posedge i_clock);
        #1;
        check(16'(o_ringing), 16'h0000);
        done("cadence");
        // Each mode run twice from a fresh burst, second time with offset
        for (int m = 0; m < 2; m++) begin
            wr(8'h62, m ? 8'h8C : 8'hFD);
            wr(8'h63, m ? 8'h01 : 8'h7E);
            wr(8'h64, m ? 8'hAB : 8'h77);
            wr(8'h65, m ? 8'h5E : 8'h01);
            wr(8'h66, m ? 8'hC8 : 8'h00);
            wr(8'h60, 8'h00);
            wr(8'h61, 8'h01);
            for (int f = 0; f < 2; f++) begin
                wr(8'h40, 8'h00);
                wr(8'h22, {3'b000, 1'b1, 2'b00, f[0], m[0]});
                wr(8'h40, 8'h04);
                idle();
                grab();
                if (f == 0) base = cap;
                else for (int k = 0; k < 4; k++) check(cap[k], base[k] + 16'h0100);
            end
            p = $signed(16'h7EFD) * $signed(base[1]);
            dlt = base[1] - base[0];
            if (m == 0) check(base[2], p[29:14] - base[0]);
            else check(dlt[15] ? -dlt : dlt, 16'h018C);
        end
        wr(8'h22, 8'h01);
        idle();
        repeat (2) @(posedge i_clock);
        #1;
        check(16'(o_ringing), 16'h0000);
        wr(8'h22, 8'h11);
        idle();
        repeat (2) @(posedge i_clock);
        #1;
        check(16'(o_ringing), 16'h0001);
        check(gap_errors, 16'h0000);
        done("waveforms");
        tally_and_finish();
    end
endmodule : ringing_waveform_generator_tb

/* File: core/ringing_waveform_generator.sv */
// Purpose: Ringing waveform generator with cadence timers and line state control
// Assumes: Single 200 MHz clock, host port reads return one cycle later
// Notes:   Samples update once per 1 ms; timers count 125 us ticks
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module ringing_waveform_generator #(
    parameter int unsigned SAMPLE_DIV = ring_gen_pkg::SAMPLE_DIV,
    parameter int unsigned TICK_DIV   = ring_gen_pkg::TICK_DIV
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    // Linefeed side
    output logic [15:0] o_sample,
    output logic        o_sample_valid,
    output logic [2:0]  o_line_state,
    output logic        o_ringing,
    output logic [3:0]  o_cm_bias_adjust,
    output logic [5:0]  o_high_battery_setting
);
    // ========================================================
    // Reset release
    logic rst_meta_q, rst_n_q;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    ring_gen_pkg::reg_req_t req;
    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // ========================================================
    // Registers
    logic [7:0]  ring_ctrl_q, line_ctrl_q, vbat_q;
    logic [15:0] on_time_q, off_time_q, offs_q, freq_q, ampl_q, phase_q, cmbias_q;
    logic        line_wr_ring;
    assign line_wr_ring = req.wr && req.addr == ring_gen_pkg::ADDR_LINE_CTRL
                          && req.wdata[2:0] == ring_gen_pkg::LINE_RINGING;

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ring_ctrl_q <= ring_gen_pkg::RESET_BYTE;
            vbat_q      <= ring_gen_pkg::RESET_BYTE;
            on_time_q   <= ring_gen_pkg::RESET_WORD;
            off_time_q  <= ring_gen_pkg::RESET_WORD;
            offs_q      <= ring_gen_pkg::RESET_WORD;
            freq_q      <= ring_gen_pkg::RESET_WORD;
            ampl_q      <= ring_gen_pkg::RESET_WORD;
            phase_q     <= ring_gen_pkg::RESET_WORD;
            cmbias_q    <= ring_gen_pkg::RESET_WORD;
        end else if (req.wr) begin
            case (req.addr)
                ring_gen_pkg::ADDR_RING_CTRL: ring_ctrl_q      <= {3'h0, req.wdata[4:0]};
                ring_gen_pkg::ADDR_ON_LO:     on_time_q[7:0]   <= req.wdata;
                ring_gen_pkg::ADDR_ON_HI:     on_time_q[15:8]  <= req.wdata;
                ring_gen_pkg::ADDR_OFF_LO:    off_time_q[7:0]  <= req.wdata;
                ring_gen_pkg::ADDR_OFF_HI:    off_time_q[15:8] <= req.wdata;
                ring_gen_pkg::ADDR_VBAT_HI:   vbat_q           <= {2'h0, req.wdata[5:0]};
                ring_gen_pkg::ADDR_OFFS_LO:   offs_q[7:0]      <= req.wdata;
                ring_gen_pkg::ADDR_OFFS_HI:   offs_q[15:8]     <= req.wdata;
                ring_gen_pkg::ADDR_FREQ_LO:   freq_q[7:0]      <= req.wdata;
                ring_gen_pkg::ADDR_FREQ_HI:   freq_q[15:8]     <= req.wdata;
                ring_gen_pkg::ADDR_AMPL_LO:   ampl_q[7:0]      <= req.wdata;
                ring_gen_pkg::ADDR_AMPL_HI:   ampl_q[15:8]     <= req.wdata;
                ring_gen_pkg::ADDR_PHASE_LO:  phase_q[7:0]     <= req.wdata;
                ring_gen_pkg::ADDR_PHASE_HI:  phase_q[15:8]    <= req.wdata;
                ring_gen_pkg::ADDR_CMBIAS:    cmbias_q         <= {12'h000, req.wdata[3:0]};
                default: ;
            endcase
        end
    end

    logic wave_sel, offs_en, on_tmr_en, off_tmr_en, osc_en, cadence_on;
    assign wave_sel   = ring_ctrl_q[ring_gen_pkg::BIT_WAVE_SEL];
    assign offs_en    = ring_ctrl_q[ring_gen_pkg::BIT_OFFS_EN];
    assign on_tmr_en  = ring_ctrl_q[ring_gen_pkg::BIT_ON_TMR_EN];
    assign off_tmr_en = ring_ctrl_q[ring_gen_pkg::BIT_OFF_TMR_EN];
    assign osc_en     = ring_ctrl_q[ring_gen_pkg::BIT_OSC_EN];
    assign cadence_on = on_tmr_en && off_tmr_en;

    // ========================================================
    // Rate dividers: 1 kHz sample enable and 125 us cadence tick
    logic [$clog2(SAMPLE_DIV)-1:0] samp_cnt_q;
    logic [$clog2(TICK_DIV)-1:0]   tick_cnt_q;
    logic                          samp_en, tick_en;
    assign samp_en = samp_cnt_q == ($clog2(SAMPLE_DIV))'(SAMPLE_DIV - 1);
    assign tick_en = tick_cnt_q == ($clog2(TICK_DIV))'(TICK_DIV - 1);
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            samp_cnt_q <= '0;
            tick_cnt_q <= '0;
        end else begin
            samp_cnt_q <= samp_en ? '0 : samp_cnt_q + 1'b1;
            tick_cnt_q <= tick_en ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // ========================================================
    // Cadence and line state
    ring_gen_pkg::cadence_t cad_q;
    logic [15:0] cad_cnt_q;
    logic [2:0]  line_q;
    logic        burst_start;
    logic        ring_active;
    logic        on_expire, off_expire;
    assign on_expire  = cad_q == ring_gen_pkg::CAD_ON && tick_en && cad_cnt_q >= on_time_q;
    assign off_expire = cad_q == ring_gen_pkg::CAD_OFF && tick_en && cad_cnt_q >= off_time_q;

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cad_q       <= ring_gen_pkg::CAD_IDLE;
            cad_cnt_q   <= '0;
            line_q      <= '0;
            burst_start <= 1'b0;
        end else begin
            burst_start <= 1'b0;
            if (req.wr && req.addr == ring_gen_pkg::ADDR_LINE_CTRL) begin
                line_q    <= req.wdata[2:0];
                cad_cnt_q <= '0;
                if (line_wr_ring) begin
                    cad_q       <= ring_gen_pkg::CAD_ON;
                    burst_start <= 1'b1;
                end else begin
                    cad_q <= ring_gen_pkg::CAD_IDLE;
                end
            end else begin
                case (cad_q)
                    ring_gen_pkg::CAD_IDLE: cad_cnt_q <= '0;
                    ring_gen_pkg::CAD_ON: begin
                        if (!on_tmr_en) begin
                            cad_cnt_q <= '0;
                        end else if (on_expire) begin
                            cad_q     <= ring_gen_pkg::CAD_OFF;
                            line_q    <= ring_gen_pkg::LINE_ONHOOK_TX;
                            cad_cnt_q <= '0;
                        end else if (tick_en) begin
                            cad_cnt_q <= cad_cnt_q + 16'h0001;
                        end
                    end
                    ring_gen_pkg::CAD_OFF: begin
                        if (!cadence_on) begin
                            cad_q <= ring_gen_pkg::CAD_IDLE;
                        end else if (off_expire) begin
                            cad_q       <= ring_gen_pkg::CAD_ON;
                            line_q      <= ring_gen_pkg::LINE_RINGING;
                            cad_cnt_q   <= '0;
                            burst_start <= 1'b1;
                        end else if (tick_en) begin
                            cad_cnt_q <= cad_cnt_q + 16'h0001;
                        end
                    end
                    default: cad_q <= ring_gen_pkg::CAD_IDLE;
                endcase
            end
        end
    end

    // Timers gate the oscillator only when enabled; otherwise the bit rules directly
    assign ring_active = cad_q == ring_gen_pkg::CAD_ON && osc_en;

    // ========================================================
    // Waveform engine
    logic signed [15:0] y1_q, y2_q, tri_q;
    logic        [15:0] half_cnt_q;
    logic               dir_up_q;
    logic signed [31:0] prod;
    logic signed [15:0] sine_next, tri_next, wave, sum;
    assign prod      = $signed(freq_q) * y1_q;
    assign sine_next = 16'(((prod >>> 14) - 32'(y2_q)));
    assign tri_next  = dir_up_q ? tri_q + $signed(freq_q) : tri_q - $signed(freq_q);
    assign wave      = wave_sel ? tri_q : y1_q;
    assign sum       = offs_en ? wave + $signed(offs_q) : wave;

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            y1_q       <= '0;
            y2_q       <= '0;
            tri_q      <= '0;
            half_cnt_q <= '0;
            dir_up_q   <= 1'b1;
        end else if (burst_start) begin
            // Sine seeds amplitude into the resonator history
            y1_q       <= $signed(phase_q);
            y2_q       <= $signed(ampl_q);
            tri_q      <= '0;
            half_cnt_q <= '0;
            dir_up_q   <= 1'b1;
        end else if (samp_en && ring_active) begin
            y1_q <= sine_next;
            y2_q <= y1_q;
            // Ramp clipped at amplitude; turns every half period of 1/8000 units
            if (dir_up_q) begin
                tri_q <= (tri_next > $signed(ampl_q)) ? $signed(ampl_q) : tri_next;
            end else begin
                tri_q <= (tri_next < -$signed(ampl_q)) ? -$signed(ampl_q) : tri_next;
            end
            if (half_cnt_q + 16'h0008 >= phase_q) begin
                half_cnt_q <= '0;
                dir_up_q   <= !dir_up_q;
            end else begin
                half_cnt_q <= half_cnt_q + 16'h0008;
            end
        end
    end

    // ========================================================
    // Outputs and read port
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_sample               <= '0;
            o_sample_valid         <= 1'b0;
            o_line_state           <= '0;
            o_ringing              <= 1'b0;
            o_cm_bias_adjust       <= '0;
            o_high_battery_setting <= '0;
            o_rdata                <= '0;
        end else begin
            o_sample_valid         <= samp_en;
            if (samp_en) begin
                o_sample <= ring_active ? sum : 16'h0000;
            end
            o_line_state           <= line_q;
            o_ringing              <= ring_active;
            o_cm_bias_adjust       <= cmbias_q[3:0];
            o_high_battery_setting <= vbat_q[5:0];
            o_rdata                <= 8'h00;
            if (req.rd) begin
                case (req.addr)
                    ring_gen_pkg::ADDR_RING_CTRL: o_rdata <= ring_ctrl_q;
                    ring_gen_pkg::ADDR_ON_LO:     o_rdata <= on_time_q[7:0];
                    ring_gen_pkg::ADDR_ON_HI:     o_rdata <= on_time_q[15:8];
                    ring_gen_pkg::ADDR_OFF_LO:    o_rdata <= off_time_q[7:0];
                    ring_gen_pkg::ADDR_OFF_HI:    o_rdata <= off_time_q[15:8];
                    ring_gen_pkg::ADDR_LINE_CTRL: o_rdata <= {5'h00, line_q};
                    ring_gen_pkg::ADDR_VBAT_HI:   o_rdata <= vbat_q;
                    ring_gen_pkg::ADDR_OFFS_LO:   o_rdata <= offs_q[7:0];
                    ring_gen_pkg::ADDR_OFFS_HI:   o_rdata <= offs_q[15:8];
                    ring_gen_pkg::ADDR_FREQ_LO:   o_rdata <= freq_q[7:0];
                    ring_gen_pkg::ADDR_FREQ_HI:   o_rdata <= freq_q[15:8];
                    ring_gen_pkg::ADDR_AMPL_LO:   o_rdata <= ampl_q[7:0];
                    ring_gen_pkg::ADDR_AMPL_HI:   o_rdata <= ampl_q[15:8];
                    ring_gen_pkg::ADDR_PHASE_LO:  o_rdata <= phase_q[7:0];
                    ring_gen_pkg::ADDR_PHASE_HI:  o_rdata <= phase_q[15:8];
                    ring_gen_pkg::ADDR_CMBIAS:    o_rdata <= cmbias_q[7:0];
                    ring_gen_pkg::ADDR_STATUS:    o_rdata <= {5'h00, cad_q};
                    default:                      o_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ========================================================
    // Checks
    a_ring_entry: assert property (@(posedge i_clock) disable iff (!rst_n_q)
        line_wr_ring |=> cad_q == ring_gen_pkg::CAD_ON && line_q == ring_gen_pkg::LINE_RINGING)
        else $error("ringing not entered after line write");
    a_on_expiry: assert property (@(posedge i_clock) disable iff (!rst_n_q)
        on_expire && !req.wr && on_tmr_en |=> cad_q == ring_gen_pkg::CAD_OFF
        && line_q == ring_gen_pkg::LINE_ONHOOK_TX)
        else $error("on expiry did not move to on-hook transmission");
    a_off_expiry: assert property (@(posedge i_clock) disable iff (!rst_n_q)
        off_expire && !req.wr && cadence_on |=> cad_q == ring_gen_pkg::CAD_ON && burst_start)
        else $error("off expiry did not restart ringing");
    a_cadence_stop: assert property (@(posedge i_clock) disable iff (!rst_n_q)
        cad_q == ring_gen_pkg::CAD_OFF && !cadence_on && !req.wr |=> cad_q == ring_gen_pkg::CAD_IDLE)
        else $error("cadence kept running with enables cleared");
    a_sample_rate: assert property (@(posedge i_clock) disable iff (!rst_n_q)
        samp_en |=> !samp_en [*8])
        else $error("sample enable too frequent");
    a_phase_reload: assert property (@(posedge i_clock) disable iff (!rst_n_q)
        burst_start |=> y1_q == $signed($past(phase_q)))
        else $error("phase not reloaded at burst start");
    a_offset_gate: assert property (@(posedge i_clock) disable iff (!rst_n_q)
        samp_en && ring_active && !offs_en && !wave_sel |=> o_sample == $past(y1_q))
        else $error("offset applied while disabled");
    a_silent_off: assert property (@(posedge i_clock) disable iff (!rst_n_q)
        samp_en && cad_q == ring_gen_pkg::CAD_OFF |=> o_sample == 16'h0000)
        else $error("waveform present during off interval");
    a_tick_count: assert property (@(posedge i_clock) disable iff (!rst_n_q)
        cad_q == ring_gen_pkg::CAD_ON && !tick_en && !req.wr && on_tmr_en |=> $stable(cad_cnt_q))
        else $error("cadence counter moved between ticks");
endmodule : ringing_waveform_generator

/* File: inc/ring_gen_pkg.sv */
// Purpose: Constants and types for the ringing waveform generator
// Assumes: 200 MHz core clock, 8-bit register port
// Notes:   Byte offsets of the register port live here
package ring_gen_pkg;
    // ========================================================
    // Timing
    localparam int unsigned CLOCK_HZ       = 200_000_000;
    localparam int unsigned SAMPLE_HZ      = 1_000;
    localparam int unsigned SAMPLE_DIV     = CLOCK_HZ / SAMPLE_HZ;
    localparam int unsigned TICK_NS        = 125_000;
    localparam int unsigned CLOCK_NS       = 5;
    localparam int unsigned TICK_DIV       = TICK_NS / CLOCK_NS;
    // ========================================================
    // Register offsets (byte addresses on the 8-bit port)
    localparam logic [7:0] ADDR_RING_CTRL  = 8'h22;
    localparam logic [7:0] ADDR_ON_LO      = 8'h30;
    localparam logic [7:0] ADDR_ON_HI      = 8'h31;
    localparam logic [7:0] ADDR_OFF_LO     = 8'h32;
    localparam logic [7:0] ADDR_OFF_HI     = 8'h33;
    localparam logic [7:0] ADDR_LINE_CTRL  = 8'h40;
    localparam logic [7:0] ADDR_VBAT_HI    = 8'h4A;
    localparam logic [7:0] ADDR_OFFS_LO    = 8'h60;
    localparam logic [7:0] ADDR_OFFS_HI    = 8'h61;
    localparam logic [7:0] ADDR_FREQ_LO    = 8'h62;
    localparam logic [7:0] ADDR_FREQ_HI    = 8'h63;
    localparam logic [7:0] ADDR_AMPL_LO    = 8'h64;
    localparam logic [7:0] ADDR_AMPL_HI    = 8'h65;
    localparam logic [7:0] ADDR_PHASE_LO   = 8'h66;
    localparam logic [7:0] ADDR_PHASE_HI   = 8'h67;
    localparam logic [7:0] ADDR_CMBIAS     = 8'h68;
    localparam logic [7:0] ADDR_STATUS     = 8'h69;
    // ========================================================
    // Field positions in ringing_control, line state codes and reset values
    localparam int unsigned BIT_WAVE_SEL   = 0;
    localparam int unsigned BIT_OFFS_EN    = 1;
    localparam int unsigned BIT_ON_TMR_EN  = 2;
    localparam int unsigned BIT_OFF_TMR_EN = 3;
    localparam int unsigned BIT_OSC_EN     = 4;
    localparam logic [2:0] LINE_RINGING    = 3'h4;
    localparam logic [2:0] LINE_ONHOOK_TX  = 3'h2;
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [15:0] RESET_WORD     = 16'h0000;

    typedef enum logic [2:0] {
        CAD_IDLE = 3'b001,
        CAD_ON   = 3'b010,
        CAD_OFF  = 3'b100
    } cadence_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;
endpackage : ring_gen_pkg
